// file: shared/port_err_defines.vh
`ifndef PORT_ERR_DEFINES_VH
`define PORT_ERR_DEFINES_VH

// Register byte offsets
`define OFS_PE_STATUS 12'h744
`define OFS_PE_REPORT 12'h748
`define OFS_PE_COUNT 12'h74C
`define OFS_TO_CONTROL 12'h750
`define OFS_TO_STATUS 12'h754
`define OFS_TO_REPORT 12'h758
`define OFS_IRQ_STATUS 12'h780
`define OFS_IRQ_MASK 12'h784
`define OFS_TO_LIMIT 12'h788

// Reset values
`define RST_PE_REPORT 2'h2
`define RST_PE_COUNT 8'h00
`define RST_TO_ENABLE 1'h1
`define RST_TO_REPORT 8'h82
`define RST_IRQ_MASK 5'h00
`define RST_TO_LIMIT 24'h00FFFF

// Counter limits
`define PE_COUNT_MAX 8'hFF
`define AGE_STEP 24'h000001

// Severity codes of the reporting fields
`define SEV_NONE 2'h0
`define SEV_COR 2'h1
`define SEV_NONFATAL 2'h2
`define SEV_FATAL 2'h3

// Event bit positions: parity in bit 0, queues in bits 4:1
`define EV_PARITY 0
`define EV_POSTED 1
`define EV_NONPOSTED 2
`define EV_COMPLETION 3
`define EV_INSERTED 4
`define EV_COUNT 5
`define QUEUE_COUNT 4

`endif

// file: logic/queue_age_timer.v
`default_nettype none

module queue_age_timer (
  // Clock and reset
  input wire clk_i,
  input wire rst_i,
  // Queue head
  input wire head_valid_i,
  input wire head_pop_i,
  // Control
  input wire enable_i,
  input wire [23:0] limit_i,
  // Discard pulse
  output reg discard_o
);

`include "port_err_defines.vh"

reg [23:0] age;

// Age restarts whenever a new TLP reaches the head or checking is off
always @(posedge clk_i) begin
  if (rst_i) begin
    age <= 24'h000000;
    discard_o <= 1'b0;
  end else begin
    discard_o <= 1'b0;
    if (!head_valid_i || head_pop_i || discard_o || !enable_i) begin
      age <= 24'h000000;
    end else if (age >= limit_i) begin
      discard_o <= 1'b1;
      age <= 24'h000000;
    end else begin
      age <= age + `AGE_STEP;
    end
  end
end

endmodule // queue_age_timer

`default_nettype wire

// file: logic/port_error_regs.v
// Behaviour
// - A parity error is reported only on a clear-to-set change of its status flag, at the field's severity.
// - Parity severity zero sends no error message.
// - Parity severity one sends a correctable message upstream.
// - Parity severity two, the reset value, sends a nonfatal message upstream.
// - Parity severity three sends a fatal message upstream.
// - Each detected parity error increments the eight-bit parity error counter.
// - The parity error counter saturates at all ones and never wraps.
// - Reading the parity error counter returns the count and clears it.
// - With time-outs enabled (the reset state), a TLP waiting past the limit is discarded.
// - A posted queue discard sets time-out status bit 0.
// - A non-posted queue discard sets time-out status bit 1.
// - A completion queue discard sets time-out status bit 2.
// - An insertion queue discard sets time-out status bit 3.
// - Each detected parity error sets the parity error status flag.
// - Each queue time-out is reported on its status rise with that queue's own two-bit severity.
//
// The Wishbone register port was left to the implementer.
`default_nettype none

`include "port_err_defines.vh"

module port_error_regs #(
  parameter [23:0] TO_LIMIT_RESET = `RST_TO_LIMIT
) (
  // Clock and resets
  input wire clk_i,
  input wire rst_i,
  input wire hot_rst_i,
  // Wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Error detection and queue heads
  input wire parity_err_i,
  input wire [3:0] head_valid_i,
  input wire [3:0] head_pop_i,
  output wire [3:0] discard_o,
  // Error messages to the root
  output reg msg_valid_o,
  output reg [1:0] msg_sev_o,
  input wire msg_ready_i,
  // Interrupt
  output reg irq_o
);

// Hot reset clears only the non-sticky state
wire soft_rst = rst_i | hot_rst_i;

reg pe_status;
reg [1:0] pe_report;
reg [7:0] pe_count;
reg to_enable;
reg [3:0] to_status;
reg [7:0] to_report;
reg [4:0] irq_status;
reg [4:0] irq_mask;
reg [23:0] to_limit;
reg [4:0] pending;

reg next_pe_status;
reg [3:0] next_to_status;
reg [7:0] next_pe_count;
reg [4:0] next_irq_status;
reg [4:0] next_pending;
reg [31:0] next_dat;
// Next values of the configuration and message state
reg [1:0] next_pe_report;
reg next_to_enable;
reg [7:0] next_to_report;
reg [23:0] next_to_limit;
reg [4:0] next_irq_mask;
reg next_msg_valid;
reg [1:0] next_msg_sev;
reg [4:0] rise;

function hit;
  input [11:0] adr;
  input [11:0] ofs;
  begin
    hit = (adr[11:2] == ofs[11:2]);
  end
endfunction

function [31:0] merge;
  input [31:0] old;
  input [31:0] data;
  input [3:0] sel;
  begin
    merge = (old & ~{{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}})
          | (data & {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}});
  end
endfunction

// Set wins over a clear arriving in the same cycle
function [4:0] w1c;
  input [4:0] old;
  input [4:0] set;
  input [4:0] clr;
  begin
    w1c = (old & ~clr) | set;
  end
endfunction

function [4:0] lowest;
  input [4:0] v;
  begin
    lowest = v & (~v + 5'h01);
  end
endfunction

// Severity field of one event source
function [1:0] sev_of;
  input [4:0] onehot;
  input [1:0] pe_sev;
  input [7:0] to_sev;
  begin
    case (onehot)
      5'h01: sev_of = pe_sev;
      5'h02: sev_of = to_sev[1:0];
      5'h04: sev_of = to_sev[3:2];
      5'h08: sev_of = to_sev[5:4];
      5'h10: sev_of = to_sev[7:6];
      default: sev_of = `SEV_NONE;
    endcase
  end
endfunction

// Bus decode; one access per request, answered one cycle later
wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wr = req & wb_we_i;
wire rd = req & ~wb_we_i;
wire [31:0] wdata = merge(32'h00000000, wb_dat_i, wb_sel_i);

wire wr_pe_status = wr & hit(wb_adr_i, `OFS_PE_STATUS);
wire wr_pe_report = wr & hit(wb_adr_i, `OFS_PE_REPORT);
wire wr_to_control = wr & hit(wb_adr_i, `OFS_TO_CONTROL);
wire wr_to_status = wr & hit(wb_adr_i, `OFS_TO_STATUS);
wire wr_to_report = wr & hit(wb_adr_i, `OFS_TO_REPORT);
wire wr_irq_mask = wr & hit(wb_adr_i, `OFS_IRQ_MASK);
wire wr_to_limit = wr & hit(wb_adr_i, `OFS_TO_LIMIT);
wire rd_pe_count = rd & hit(wb_adr_i, `OFS_PE_COUNT);
wire rd_irq_status = rd & hit(wb_adr_i, `OFS_IRQ_STATUS);
// Write-one clear of the queue status bits
wire [3:0] to_clear = wr_to_status ? wdata[3:0] : 4'h0;

// Queue age timers, one per input queue
genvar q;
generate
  for (q = 0; q < `QUEUE_COUNT; q = q + 1) begin : g_age
    queue_age_timer queue_age_timer_inst (
      .clk_i(clk_i),
      .rst_i(soft_rst),
      .head_valid_i(head_valid_i[q]),
      .head_pop_i(head_pop_i[q]),
      .enable_i(to_enable),
      .limit_i(to_limit),
      .discard_o(discard_o[q])
    );
  end
endgenerate

// Status flags
always @* begin
  next_pe_status = pe_status;
  next_to_status = to_status;
  if (parity_err_i) begin
    next_pe_status = 1'b1;
  end else if (wr_pe_status & wdata[0]) begin
    next_pe_status = 1'b0;
  end
  // A discard in the same cycle as a write-one clear keeps the bit set
  next_to_status[0] = discard_o[0] | (to_status[0] & ~to_clear[0]);
  next_to_status[1] = discard_o[1] | (to_status[1] & ~to_clear[1]);
  next_to_status[2] = discard_o[2] | (to_status[2] & ~to_clear[2]);
  next_to_status[3] = discard_o[3] | (to_status[3] & ~to_clear[3]);
end

// A report is queued only on a clear-to-set change, never while a bit stays set
always @* begin
  rise[0] = next_pe_status & ~pe_status;
  rise[1] = next_to_status[0] & ~to_status[0];
  rise[2] = next_to_status[1] & ~to_status[1];
  rise[3] = next_to_status[2] & ~to_status[2];
  rise[4] = next_to_status[3] & ~to_status[3];
end

// Saturating, read-to-clear parity counter
always @* begin
  next_pe_count = rd_pe_count ? 8'h00 : pe_count;
  if (parity_err_i && (rd_pe_count || pe_count != `PE_COUNT_MAX)) begin
    next_pe_count = next_pe_count + 8'h01;
  end
end

// Interrupt status is cleared by reading it
always @* begin
  next_irq_status = w1c(irq_status, {discard_o, parity_err_i},
                        rd_irq_status ? 5'h1F : 5'h00);
end

// Configuration writes; each field needs the byte lane that carries it
always @* begin
  next_pe_report = pe_report;
  next_to_enable = to_enable;
  next_to_report = to_report;
  next_to_limit = to_limit;
  next_irq_mask = irq_mask;
  if (wr_pe_report & wb_sel_i[0]) begin
    next_pe_report = wdata[1:0];
  end
  if (wr_to_control & wb_sel_i[0]) begin
    next_to_enable = wdata[0];
  end
  if (wr_to_report & wb_sel_i[0]) begin
    next_to_report = wdata[7:0];
  end
  if (wr_to_limit & wb_sel_i[0]) begin
    next_to_limit[7:0] = wb_dat_i[7:0];
  end
  if (wr_to_limit & wb_sel_i[1]) begin
    next_to_limit[15:8] = wb_dat_i[15:8];
  end
  if (wr_to_limit & wb_sel_i[2]) begin
    next_to_limit[23:16] = wb_dat_i[23:16];
  end
  if (wr_irq_mask & wb_sel_i[0]) begin
    next_irq_mask = wdata[4:0];
  end
end

// Message arbitration: lowest event index first
wire load = ~msg_valid_o | msg_ready_i;
wire [4:0] grant = load ? lowest(pending) : 5'h00;
wire [1:0] grant_sev = sev_of(grant, pe_report, to_report);

always @* begin
  next_pending = (pending & ~grant) | rise;
end

// A granted source whose field reads zero is dropped here
always @* begin
  next_msg_valid = msg_valid_o;
  next_msg_sev = msg_sev_o;
  if (load) begin
    next_msg_valid = (grant != 5'h00) && (grant_sev != `SEV_NONE);
    next_msg_sev = grant_sev;
  end
end

// Read data
always @* begin
  next_dat = 32'h00000000;
  if (hit(wb_adr_i, `OFS_PE_STATUS)) begin
    next_dat[0] = pe_status;
  end else if (hit(wb_adr_i, `OFS_PE_REPORT)) begin
    next_dat[1:0] = pe_report;
  end else if (hit(wb_adr_i, `OFS_PE_COUNT)) begin
    next_dat[7:0] = pe_count;
  end else if (hit(wb_adr_i, `OFS_TO_CONTROL)) begin
    next_dat[0] = to_enable;
  end else if (hit(wb_adr_i, `OFS_TO_STATUS)) begin
    next_dat[3:0] = to_status;
  end else if (hit(wb_adr_i, `OFS_TO_REPORT)) begin
    next_dat[7:0] = to_report;
  end else if (hit(wb_adr_i, `OFS_IRQ_STATUS)) begin
    next_dat[4:0] = irq_status;
  end else if (hit(wb_adr_i, `OFS_IRQ_MASK)) begin
    next_dat[4:0] = irq_mask;
  end else if (hit(wb_adr_i, `OFS_TO_LIMIT)) begin
    next_dat[23:0] = to_limit;
  end
end

// Bus answer; unmapped addresses still get an ack, reading zero
always @(posedge clk_i) begin
  if (rst_i) begin
    wb_ack_o <= 1'b0;
    wb_dat_o <= 32'h00000000;
  end else begin
    wb_ack_o <= req;
    if (rd) begin
      wb_dat_o <= next_dat;
    end
  end
end

// Sticky configuration, reset only by the full reset
always @(posedge clk_i) begin
  if (rst_i) begin
    pe_report <= `RST_PE_REPORT;
    pe_count <= `RST_PE_COUNT;
    to_enable <= `RST_TO_ENABLE;
    to_report <= `RST_TO_REPORT;
    to_limit <= TO_LIMIT_RESET;
  end else begin
    pe_count <= next_pe_count;
    pe_report <= next_pe_report;
    to_enable <= next_to_enable;
    to_report <= next_to_report;
    to_limit <= next_to_limit;
  end
end

// Non-sticky status, cleared by either reset
always @(posedge clk_i) begin
  if (soft_rst) begin
    pe_status <= 1'b0;
    to_status <= 4'h0;
    irq_status <= 5'h00;
    irq_mask <= `RST_IRQ_MASK;
    irq_o <= 1'b0;
  end else begin
    pe_status <= next_pe_status;
    to_status <= next_to_status;
    irq_status <= next_irq_status;
    irq_mask <= next_irq_mask;
    irq_o <= |(next_irq_status & irq_mask);
  end
end

// Upstream messages, held until the root takes them
always @(posedge clk_i) begin
  if (soft_rst) begin
    pending <= 5'h00;
    msg_valid_o <= 1'b0;
    msg_sev_o <= `SEV_NONE;
  end else begin
    pending <= next_pending;
    msg_valid_o <= next_msg_valid;
    msg_sev_o <= next_msg_sev;
  end
end

endmodule // port_error_regs

`default_nettype wire

// file: sim/root_model.sv
`default_nettype none
module root_model (
  // Clock
  input wire logic clk_i,
  // Message link
  input wire logic msg_valid_i,
  input wire logic slow_i,
  output logic msg_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tick = 1'b0;
  initial msg_ready_o = 1'b0;
  // Slow mode takes every other cycle, so held messages get exercised
  always @(posedge clk_i) begin
    tick <= ~tick;
    msg_ready_o <= msg_valid_i && (!slow_i || tick);
  end
endmodule // root_model
`default_nettype wire

// file: sim/port_error_regs_assertions.sv
`default_nettype none
module port_error_checks #(
  parameter [23:0] TO_LIMIT_RESET = 24'h00FFFF
) (
  // Clock and resets
  input wire clk_i,
  input wire rst_i,
  input wire hot_rst_i,
  // Bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Messages
  input wire msg_valid_o,
  input wire [1:0] msg_sev_o,
  input wire msg_ready_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_i); endclocking
  // Hot reset flushes pending messages, so checks pause across it
  default disable iff (rst_i || hot_rst_i);
  wire rd = wb_ack_o && !wb_we_i;
  property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack long");
  property p_cnt; rd && wb_adr_i == 12'h74C |-> wb_dat_o[31:8] == 24'h0; endproperty
  a_cnt: assert property (p_cnt) else $error("count bits");
  property p_rep; rd && wb_adr_i == 12'h748 |-> wb_dat_o[31:2] == 30'h0; endproperty
  a_rep: assert property (p_rep) else $error("report bits");
  property p_sts; rd && wb_adr_i == 12'h754 |-> wb_dat_o[31:4] == 28'h0; endproperty
  a_sts: assert property (p_sts) else $error("status bits");
  property p_ena; rd && wb_adr_i == 12'h750 |-> wb_dat_o[31:1] == 31'h0; endproperty
  a_ena: assert property (p_ena) else $error("enable bits");
  property p_hold; msg_valid_o && !msg_ready_i |=> msg_valid_o && $stable(msg_sev_o); endproperty
  a_hold: assert property (p_hold) else $error("message lost");
  property p_sev; msg_valid_o |-> msg_sev_o != 2'h0; endproperty
  a_sev: assert property (p_sev) else $error("empty severity");
  c_msg: cover property (msg_valid_o && msg_ready_i);
  c_wait: cover property (msg_valid_o && !msg_ready_i);
  c_cnt: cover property (rd && wb_adr_i == 12'h74C);
endmodule // port_error_checks
bind port_error_regs port_error_checks #(.TO_LIMIT_RESET(TO_LIMIT_RESET)) port_error_checks_inst (
  .clk_i(clk_i), .rst_i(rst_i), .hot_rst_i(hot_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .msg_valid_o(msg_valid_o),
  .msg_sev_o(msg_sev_o), .msg_ready_i(msg_ready_i)
);
`default_nettype wire

// file: sim/port_error_regs_bench.sv
`default_nettype none
`define CHK(n, e, s) chk(n, e, s);
module port_error_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [23:0] LIM = 24'h000010;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hot_rst_i = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [11:0] wb_adr_i = 12'h0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic parity_err_i = 1'b0;
  logic [3:0] head_valid_i = 4'h0;
  logic [3:0] head_pop_i = 4'h0;
  logic slow = 1'b0;
  wire [31:0] wb_dat_o;
  wire [3:0] discard_o;
  wire [1:0] msg_sev_o;
  wire wb_ack_o, msg_valid_o, msg_ready_i, irq_o;
  logic [31:0] exp_rd[$];
  logic [1:0] exp_msg[$];
  int fails = 0, total_checks = 0, cycles = 0, discs = 0, d0 = 0, seed = 14;
  always #4 clk_i = ~clk_i;
  port_error_regs #(.TO_LIMIT_RESET(LIM)) port_error_regs_inst (
    .clk_i(clk_i), .rst_i(rst_i), .hot_rst_i(hot_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .parity_err_i(parity_err_i), .head_valid_i(head_valid_i), .head_pop_i(head_pop_i),
    .discard_o(discard_o), .msg_valid_o(msg_valid_o), .msg_sev_o(msg_sev_o), .msg_ready_i(msg_ready_i),
    .irq_o(irq_o));
  root_model root_model_inst (.clk_i(clk_i), .msg_valid_i(msg_valid_o), .slow_i(slow), .msg_ready_o(msg_ready_i));
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (e !== s) begin
      fails++;
      $display("unexpected %s exp %0h got %0h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (wb_ack_o === 1'b1 && !wb_we_i) `CHK("rdata", exp_rd.pop_front(), wb_dat_o)
    if (msg_valid_o === 1'b1 && msg_ready_i) `CHK("sev", exp_msg.pop_front(), msg_sev_o)
    if (discard_o !== 4'h0) discs++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic bus(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1 && ++n < 40);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  task automatic pe(input int gap);
    @(posedge clk_i);
    parity_err_i <= 1'b1;
    @(posedge clk_i);
    parity_err_i <= 1'b0;
    repeat (gap) @(posedge clk_i);
  endtask
  // Each queue in turn; the status read also proves the previous bit was cleared
  task automatic tq(input int q);
    int n = 0;
    slow <= q[0];
    if (q != 0) exp_msg.push_back(q[1:0]);
    @(posedge clk_i);
    head_valid_i[q] <= 1'b1;
    do @(posedge clk_i); while (discard_o[q] !== 1'b1 && ++n < 99);
    head_valid_i[q] <= 1'b0;
    head_pop_i[q] <= 1'b1;
    `CHK("wait", 1'b1, n >= LIM + 1 && n <= LIM + 2)
    @(posedge clk_i);
    head_pop_i[q] <= 1'b0;
    repeat (4) @(posedge clk_i);
    rd(12'h754, 32'h1 << q);
    wr(12'h754, 32'h1 << q);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(12'h748, 32'h2);
    rd(12'h74C, 32'h0);
    rd(12'h750, 32'h1);
    rd(12'h754, 32'h0);
    rd(12'h758, 32'h82);
    rd(12'h788, LIM);
    wr(12'h7F0, 32'hFFFFFFFF);
    rd(12'h7F0, 32'h0);
    wr(12'h748, 32'h0);
    wr(12'h784, 32'h1);
    pe(3);
    `CHK("irq", 1'b1, irq_o)
    rd(12'h780, 32'h1);
    repeat (3) @(posedge clk_i);
    `CHK("irq", 1'b0, irq_o)
    wr(12'h784, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(12'h744, 32'h1);
      wr(12'h748, s);
      if (s != 0) exp_msg.push_back(s[1:0]);
      pe(4);
      rd(12'h744, 32'h1);
    end
    rd(12'h74C, 32'h5);
    rd(12'h74C, 32'h0);
    wr(12'h744, 32'h1);
    exp_msg.push_back(2'h3);
    repeat (260) pe($random(seed) & 1);
    wr(12'h744, 32'h0);
    rd(12'h744, 32'h1);
    hot_rst_i <= 1'b1;
    @(posedge clk_i);
    hot_rst_i <= 1'b0;
    rd(12'h744, 32'h0);
    rd(12'h748, 32'h3);
    rd(12'h74C, 32'hFF);
    rd(12'h74C, 32'h0);
    wr(12'h758, 32'hE4);
    wr(12'h784, 32'h1E);
    for (int q = 0; q < 4; q++) tq(q);
    `CHK("irq", 1'b1, irq_o)
    rd(12'h780, 32'h1E);
    wr(12'h750, 32'h0);
    d0 = discs;
    head_valid_i[0] <= 1'b1;
    repeat (60) @(posedge clk_i);
    `CHK("discards", d0, discs)
    head_valid_i[0] <= 1'b0;
    repeat (20) @(posedge clk_i);
    `CHK("irq", 1'b0, irq_o)
    `CHK("left", 0, exp_msg.size() + exp_rd.size())
    summarize();
  end
endmodule // port_error_regs_bench
`default_nettype wire
